// file: hdl/rtcci_ctrl.sv
// Purpose: control-page interrupt enable, interrupt flag, status and reset registers.
// Assumes: accesses come one per cycle from the serial interface byte decoder.
// Notes:   reset_i is the power-on reset of the device.
// Summary of operation
// - unimplemented bits of the four registers always read back as zero
// - writing one to restart bit pulses a system restart; zero does nothing
// - power-on flag is set at power-up and held until written zero
// - self-recovery status flag sets whenever a self-recovery reset occurred
`include "rtcci_regs.svh"
module rtcci_ctrl (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_i,
    // register port
    input  wire rtcci_pkg::rtcci_req_t reg_req_i,
    output logic [7:0]                reg_rdata_o,
    output logic                      reg_rvalid_o,
    // hardware events and levels
    input  wire rtcci_pkg::rtcci_evt_t evt_i,
    input  wire logic                 nvm_busy_i,
    // outputs to the device
    output logic                      irq_o,
    output logic                      system_restart_o
);
    import rtcci_pkg::*;

    localparam int NCELL = 9;
    localparam int C_V1  = 5;
    localparam int C_V2  = 6;
    localparam int C_SR  = 7;
    localparam int C_PON = 8;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic       wr_en;
    logic       wr_flags;
    logic       wr_status;
    logic       wr_reset;
    logic [4:0] src_evt;

    always_comb begin
        wr_en     = reg_req_i.wr & hit(reg_req_i.addr, `RTCCI_OFS_IRQ_EN);
        wr_flags  = reg_req_i.wr & hit(reg_req_i.addr, `RTCCI_OFS_IRQ_FLAGS);
        wr_status = reg_req_i.wr & hit(reg_req_i.addr, `RTCCI_OFS_STATUS);
        wr_reset  = reg_req_i.wr & hit(reg_req_i.addr, `RTCCI_OFS_RESET);
        src_evt   = evt_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag cells: 0..4 interrupt flags, then lowvolt1, lowvolt2, selfrec, power-on

    localparam logic [NCELL-1:0] CELL_INIT = `RTCCI_FLAG_CELLS_RST;

    logic [NCELL-1:0] cell_set;
    logic [NCELL-1:0] cell_clr;
    logic [NCELL-1:0] cell_q;

    always_comb begin
        cell_set = '0;
        cell_clr = '0;
        cell_set[4:0]  = src_evt;
        cell_set[C_V1] = evt_i.lowvolt1;
        cell_set[C_V2] = evt_i.lowvolt2;
        cell_set[C_SR] = evt_i.selfrec;
        // writing zero clears a flag; writing one leaves it alone
        if (wr_flags) begin
            cell_clr[4:0] = ~reg_req_i.wdata[`RTCCI_SRC_MSB:`RTCCI_SRC_LSB];
        end
        // a restart drops pending interrupts but keeps the status history
        if (system_restart_o) begin
            cell_clr[4:0] = 5'h1F;
        end
        if (wr_status) begin
            cell_clr[C_V1]  = ~reg_req_i.wdata[`RTCCI_ST_LOWVOLT1];
            cell_clr[C_V2]  = ~reg_req_i.wdata[`RTCCI_ST_LOWVOLT2];
            cell_clr[C_SR]  = ~reg_req_i.wdata[`RTCCI_ST_SELFREC];
            cell_clr[C_PON] = ~reg_req_i.wdata[`RTCCI_ST_POWER_ON];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCELL; g++) begin : gen_cell
            rtcci_sticky_bit #(
                .INIT (CELL_INIT[g])
            ) u_cell (
                .sys_clk_i (sys_clk_i),
                .reset_i   (reset_i),
                .set_i     (cell_set[g]),
                .clr_i     (cell_clr[g]),
                .flag_o    (cell_q[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // enables, restart, interrupt, read data

    logic [4:0] irq_en;
    logic [4:0] next_irq_en;
    logic       next_restart;
    logic       next_irq;
    logic [7:0] next_rdata;
    logic       next_rvalid;

    always_comb begin
        next_irq_en = irq_en;
        if (system_restart_o) begin
            next_irq_en = `RTCCI_IRQ_EN_RST;
        end else if (wr_en) begin
            next_irq_en = reg_req_i.wdata[`RTCCI_SRC_MSB:`RTCCI_SRC_LSB];
        end
        next_restart = wr_reset & reg_req_i.wdata[`RTCCI_RST_RESTART];
        next_irq     = |(cell_q[4:0] & irq_en);
        next_rvalid  = reg_req_i.rd;
        next_rdata   = 8'h00;
        if (reg_req_i.rd) begin
            unique case (1'b1)
                hit(reg_req_i.addr, `RTCCI_OFS_IRQ_EN): begin
                    next_rdata[`RTCCI_SRC_MSB:`RTCCI_SRC_LSB] = irq_en;
                end
                hit(reg_req_i.addr, `RTCCI_OFS_IRQ_FLAGS): begin
                    next_rdata[`RTCCI_SRC_MSB:`RTCCI_SRC_LSB] = cell_q[4:0];
                end
                hit(reg_req_i.addr, `RTCCI_OFS_STATUS): begin
                    next_rdata[`RTCCI_ST_NVM_BUSY] = nvm_busy_i;
                    next_rdata[`RTCCI_ST_POWER_ON] = cell_q[C_PON];
                    next_rdata[`RTCCI_ST_SELFREC]  = cell_q[C_SR];
                    next_rdata[`RTCCI_ST_LOWVOLT2] = cell_q[C_V2];
                    next_rdata[`RTCCI_ST_LOWVOLT1] = cell_q[C_V1];
                end
                // restart bit is a trigger only and reads back as zero
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_en           <= `RTCCI_IRQ_EN_RST;
            system_restart_o <= 1'b0;
            irq_o            <= 1'b0;
            reg_rdata_o      <= 8'h00;
            reg_rvalid_o     <= 1'b0;
        end else begin
            irq_en           <= next_irq_en;
            system_restart_o <= next_restart;
            irq_o            <= next_irq;
            reg_rdata_o      <= next_rdata;
            reg_rvalid_o     <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] rd_addr_q;
    always_ff @(posedge sys_clk_i) begin
        rd_addr_q <= reg_req_i.addr;
    end

    sequence restart_write_s;
        wr_reset && reg_req_i.wdata[`RTCCI_RST_RESTART];
    endsequence

    sequence quiet_write_s;
        wr_reset && !reg_req_i.wdata[`RTCCI_RST_RESTART];
    endsequence

    unused_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        reg_rvalid_o |-> (reg_rdata_o[6] == 1'b0) &&
            ((rd_addr_q == `RTCCI_OFS_STATUS) ? (reg_rdata_o[1:0] == 2'b00)
                                              : (reg_rdata_o[7:5] == 3'b000)))
        else $error("unimplemented bit read as one");

    restart_fire_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        restart_write_s |=> system_restart_o ##1 (irq_en == 5'h00))
        else $error("restart write gave no restart");

    restart_quiet_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        quiet_write_s |=> !system_restart_o)
        else $error("zero write caused a restart");

    pon_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cell_q[C_PON] && !(wr_status && !reg_req_i.wdata[`RTCCI_ST_POWER_ON])
        |=> cell_q[C_PON])
        else $error("power-on flag lost without a clear");

    pon_init_a: assert property (@(posedge sys_clk_i)
        reset_i |=> cell_q[C_PON])
        else $error("power-on flag not set after power-up");

    selfrec_set_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i.selfrec |=> cell_q[C_SR] && cell_q[4])
        else $error("self-recovery event not flagged");

    irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        irq_o |-> $past(|(cell_q[4:0] & irq_en)))
        else $error("interrupt without an enabled flag");

    irq_raise_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(cell_q[1]) && irq_en[1] && !wr_flags && !wr_en && !system_restart_o
        |=> irq_o)
        else $error("enabled countdown flag gave no interrupt");

    // the converse of irq_gate_a: an enabled flag may never be ignored
    irq_follow_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        |(cell_q[4:0] & irq_en) |=> irq_o)
        else $error("enabled flag gave no interrupt");

    // an event in the restart cycle is allowed to survive, so only quiet cycles count
    restart_clear_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        system_restart_o && (src_evt == 5'h00) |=> (cell_q[4:0] == 5'h00) && (irq_en == 5'h00))
        else $error("restart left interrupts pending");

    selfrec_quiet_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !cell_q[C_SR] && !evt_i.selfrec |=> !cell_q[C_SR])
        else $error("self-recovery status set without an event");
endmodule

// file: shared/rtcci_regs.svh
`ifndef RTCCI_REGS_SVH
`define RTCCI_REGS_SVH

// register offsets on the serial register port
`define RTCCI_OFS_IRQ_EN     8'h01
`define RTCCI_OFS_IRQ_FLAGS  8'h02
`define RTCCI_OFS_STATUS     8'h03
`define RTCCI_OFS_RESET      8'h04

// field positions in interrupt_enable and interrupt_flags
`define RTCCI_SRC_LSB        0
`define RTCCI_SRC_MSB        4
// field positions in device_status
`define RTCCI_ST_LOWVOLT1    2
`define RTCCI_ST_LOWVOLT2    3
`define RTCCI_ST_SELFREC     4
`define RTCCI_ST_POWER_ON    5
`define RTCCI_ST_NVM_BUSY    7
// field position in system_reset_trigger
`define RTCCI_RST_RESTART    4

// reset values
`define RTCCI_IRQ_EN_RST     5'h00
`define RTCCI_FLAG_CELLS_RST 9'h100

`endif

// file: shared/rtcci_pkg.sv
package rtcci_pkg;

    // one access from the serial interface's byte decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcci_req_t;

    // one-cycle event pulses from the clock core, same order as the enable bits
    typedef struct packed {
        logic selfrec;
        logic lowvolt2;
        logic lowvolt1;
        logic countdown;
        logic alarm;
    } rtcci_evt_t;

endpackage

// file: hdl/rtcci_sticky_bit.sv
// Purpose: one sticky flag, set by hardware, cleared by a party outside.
// Assumes: set and clr are synchronous one-cycle strobes.
// Notes:   set wins over a clear in the same cycle, so no event is lost.
module rtcci_sticky_bit #(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // control
    input  wire logic set_i,
    input  wire logic clr_i,
    // state
    output logic      flag_o
);
    logic next_flag;

    always_comb begin
        next_flag = set_i | (flag_o & ~clr_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flag_o <= INIT;
        end else begin
            flag_o <= next_flag;
        end
    end
endmodule

// file: tb/rtcci_host_model.sv
// Purpose: host side of the register port, single byte reads and writes.
// Assumes: requests change at the falling clock edge, one at a time.
// Notes:   released address and data show the inverse of the last value.
module rtcci_host_model
    import rtcci_pkg::*;
(
    // clock
    input  wire logic             sys_clk_i,
    // register port
    output rtcci_pkg::rtcci_req_t req_o,
    input  wire logic [7:0]       rdata_i,
    input  wire logic             rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // the host restarts by writing one and clears flags by writing zero
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule

// file: tb/test_rtc_control_interrupt_regs.sv
// Purpose: self-checking bench for the control-page register group.
// Assumes: inputs change at the falling edge; answers sampled a half cycle later.
// Notes:   flags are cleared between tests so each starts from a known state.
module test_rtc_control_interrupt_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcci_pkg::*;

    logic       sys_clk;
    logic       reset;
    rtcci_req_t req;
    rtcci_evt_t evt;
    logic       nvm_busy;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
    logic       restart;
    int         n_fail;
    int         n_compared;
    int         cycles;

    rtcci_ctrl dut (
        .sys_clk_i        (sys_clk),
        .reset_i          (reset),
        .reg_req_i        (req),
        .reg_rdata_o      (rdata),
        .reg_rvalid_o     (rvalid),
        .evt_i            (evt),
        .nvm_busy_i       (nvm_busy),
        .irq_o            (irq),
        .system_restart_o (restart)
    );

    rtcci_host_model host (
        .sys_clk_i (sys_clk),
        .req_o     (req),
        .rdata_i   (rdata),
        .rvalid_i  (rvalid)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // a hang is cut short well beyond the fewer than 150 cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd_byte(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask

    task automatic pulse(input logic [4:0] e);
        @(negedge sys_clk);
        evt = e;
        @(negedge sys_clk);
        evt = '0;
    endtask

    task automatic t_reset();
        rchk(8'h01, 8'h00);
        rchk(8'h02, 8'h00);
        rchk(8'h03, 8'h20);
        rchk(8'h04, 8'h00);
        rchk(8'h05, 8'h00);
        chk({6'h00, irq, restart}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_unused();
        host.wr_byte(8'h01, 8'hFF);
        rchk(8'h01, 8'h1F);
        host.wr_byte(8'h02, 8'hFF);
        rchk(8'h02, 8'h00);
        host.wr_byte(8'h03, 8'hFF);
        nvm_busy = 1'b1;
        rchk(8'h03, 8'hA0);
        nvm_busy = 1'b0;
        host.wr_byte(8'h01, 8'h00);
        $display("test unused done");
    endtask

    task automatic t_irq();
        logic [4:0] m;
        for (int i = 0; i < 5; i++) begin
            m = 5'h01 << i;
            host.wr_byte(8'h01, {3'h0, m});
            pulse(~m);
            rchk(8'h02, {3'h0, ~m});
            chk({7'h00, irq}, 8'h00);
            pulse(m);
            rchk(8'h03, 8'h3C);
            chk({7'h00, irq}, 8'h01);
            host.wr_byte(8'h02, 8'h00);
            host.wr_byte(8'h03, 8'h20);
            rchk(8'h02, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
        rchk(8'h03, 8'h20);
        $display("test irq done");
    endtask

    task automatic t_restart();
        host.wr_byte(8'h01, 8'h1F);
        host.wr_byte(8'h04, 8'hEF);
        chk({7'h00, restart}, 8'h00);
        rchk(8'h04, 8'h00);
        rchk(8'h01, 8'h1F);
        // pending interrupts that the restart must drop
        pulse(5'h03);
        rchk(8'h02, 8'h03);
        chk({7'h00, irq}, 8'h01);
        host.wr_byte(8'h04, 8'h10);
        chk({7'h00, restart}, 8'h01);
        @(negedge sys_clk);
        chk({7'h00, restart}, 8'h00);
        rchk(8'h01, 8'h00);
        rchk(8'h02, 8'h00);
        chk({7'h00, irq}, 8'h00);
        host.wr_byte(8'h03, 8'h00);
        rchk(8'h03, 8'h00);
        $display("test restart done");
    endtask

    // a second power-up must bring the power-on flag back after it was cleared
    task automatic t_repower();
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        rchk(8'h03, 8'h20);
        rchk(8'h01, 8'h00);
        chk({6'h00, irq, restart}, 8'h00);
        $display("test repower done");
    endtask

    initial begin
        reset = 1'b1;
        evt = '0;
        nvm_busy = 1'b0;
        repeat (8) @(negedge sys_clk);
        reset = 1'b0;
        t_reset();
        t_unused();
        t_irq();
        t_restart();
        t_repower();
        tally_and_finish();
    end
endmodule
